// [verilog/tsc_pkg.sv]
/*
  tsc_pkg: status word layout, reset values and sequencing constants
  of the trap/status control block. Assumes a 32-bit status word.
*/
package tsc_pkg;
  localparam int PSW_W = 32;
  localparam int ADDR_W = 32;
  localparam int BOOT_MAP_BIT = 31;
  localparam int NEXT_KRN_BIT = 30;
  localparam int KRN_BIT = 29;
  localparam int PRIV_BIT = 28;
  localparam int CHK_INH_BIT = 27;
  localparam int PID_LSB = 19;
  localparam int PID_W = 8;
  localparam int BANK_A_LSB = 17;
  localparam int BANK_B_LSB = 15;
  localparam int BANK_W = 2;
  localparam int IMAP_BYP_BIT = 14;
  localparam int DMAP_BYP_BIT = 13;
  localparam int CAUSE_LSB = 6;
  localparam int CAUSE_W = 7;
  localparam int LIT_LSB = 0;
  localparam int LIT_W = 6;
  // cause vector order, msb first: ext ill itf dtf wpv cop usr
  localparam int C_EXT = 6;
  localparam int C_ILL = 5;
  localparam int C_ITF = 4;
  localparam int C_DTF = 3;
  localparam int C_WPV = 2;
  localparam int C_COP = 1;
  localparam int C_USR = 0;
  localparam logic [ADDR_W-1:0] HANDLER_ADDR = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] RESET_FETCH = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] BOOT_ADDR = 32'h0000_1000;
  localparam int CLR_MIN_CYCLES = 1024;
  localparam int CACHE_LINES = 1024;
  typedef enum logic [1:0] {TSC_CLEAR, TSC_RUN, TSC_HALT} tsc_state_t;
endpackage

// [verilog/tsc_sub_if.sv]
/*
  tsc_sub_if: carrier between the top and its cache-clear sequencer and
  restart queue. Assumes all ends run on the one processor clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tsc_sub_if #(parameter int LINE_W = 10, parameter int ADDR_W = 32);
  logic clr_busy;
  logic clr_done;
  logic [LINE_W-1:0] clr_line;
  logic rq_shift;
  logic [ADDR_W-1:0] rq_pc;
  logic rq_freeze;
  logic rq_thaw;
  logic [ADDR_W-1:0] rq_first;
  logic [ADDR_W-1:0] rq_second;
  modport clr (output clr_busy, output clr_done, output clr_line);
  modport rq (input rq_shift, input rq_pc, input rq_freeze, input rq_thaw,
    output rq_first, output rq_second);
  modport top (input clr_busy, input clr_done, input clr_line,
    output rq_shift, output rq_pc, output rq_freeze, output rq_thaw,
    input rq_first, input rq_second);
endinterface
`default_nettype wire

// [verilog/tsc_clear_seq.sv]
/*
  tsc_clear_seq: walks every cache line after reset (repeatedly when LINES < MIN_CYC) and holds busy
  for at least the minimum clear time. Assumes reset starts it.
*/
`timescale 1ns/1ps
`default_nettype none
module tsc_clear_seq
  import tsc_pkg::*;
#(
  parameter int LINES = CACHE_LINES,
  parameter int MIN_CYC = CLR_MIN_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  tsc_sub_if.clr sub
);
  localparam int TOTAL = (LINES > MIN_CYC) ? LINES : MIN_CYC;
  localparam int CW = $clog2(TOTAL + 1);
  logic [CW-1:0] cnt_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= '0;
      sub.clr_busy <= 1'b1;
      sub.clr_done <= 1'b0;
    end
    else if (sub.clr_busy)
    begin
      // busy spans TOTAL cycles, never fewer than the minimum
      if (cnt_r == CW'(TOTAL - 1))
        sub.clr_busy <= 1'b0;
      sub.clr_done <= (cnt_r == CW'(TOTAL - 1));
      cnt_r <= cnt_r + 1'b1;
    end
    else
      sub.clr_done <= 1'b0;
  end
  assign sub.clr_line = cnt_r[$bits(sub.clr_line)-1:0];
endmodule
`default_nettype wire

// [verilog/tsc_restart_q.sv]
/*
  tsc_restart_q: two-entry queue of the last issued instruction
  addresses. Assumes the pipeline pulses shift once per issue.
*/
`timescale 1ns/1ps
`default_nettype none
module tsc_restart_q
  import tsc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  tsc_sub_if.rq sub
);
  logic frozen_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      frozen_r <= 1'b0;
    else if (sub.rq_freeze)
      frozen_r <= 1'b1;
    else if (sub.rq_thaw)
      frozen_r <= 1'b0;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sub.rq_first <= '0;
      sub.rq_second <= '0;
    end
    else if (sub.rq_shift && !frozen_r && !sub.rq_freeze)
    begin
      sub.rq_second <= sub.rq_first;
      sub.rq_first <= sub.rq_pc;
    end
  end
endmodule
`default_nettype wire

// [verilog/tsc_top.sv]
/*
  tsc_top: processor status word, trap entry, reset cache clear and halt
  control. Assumes the pipeline reports decoded ops and faults of the
  executing instruction, all synchronous to i_ref_clk.
*/
// Behaviour
// RULE1: bank A selects first source/destination bank
// RULE2: bank B selects second source bank
// RULE3: bypass bits skip fetch/data translation
// RULE4: outside irq flag tracks memory controller interrupt
// RULE5: forbidden op flag for illegal user ops
// RULE6: separate flags for translation and read-only faults
// RULE7: fpu-or-timer flag on coprocessor trap or timer
// RULE8: soft trap flag and literal capture
// RULE9: several cause flags may be set together
// RULE10: writes reach only the writable fields
// RULE11: causes update in user, hold in kernel
// RULE12: reset value of status word control bits
// RULE13: fetch pointer zeroed, all cache lines cleared
// RULE14: start at boot address after clear
// RULE15: clear lasts 1024 cycles, memory reset held
// RULE16: trap loads handler address into fetch pointer
// RULE17: trap sets kernel, next-kernel and bypasses
// RULE18: restart queue freezes on trap, exit restarts
// RULE19: kernel-mode translation or read-only fault halts
// RULE20: kernel abort, trap or reserved op halts
// RULE21: parity error halts unless check inhibited
// RULE22: halt lasts until external reset
// RULE23: kernel state follows previous next-kernel
// RULE24: kernel ignores interrupts, allows privileged ops
// RULE25: privilege enable allows privileged ops in user
// RULE26: check-inhibit suppresses parity checking
`timescale 1ns/1ps
`default_nettype none
module tsc_top
  import tsc_pkg::*;
#(
  parameter int LINES = CACHE_LINES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psw_wr,
  input wire logic [PSW_W-1:0] i_psw_wdata,
  input wire logic i_ex_valid,
  input wire logic [ADDR_W-1:0] i_ex_pc,
  input wire logic i_op_special,
  input wire logic i_op_set_queue,
  input wire logic i_op_kernel_exit,
  input wire logic i_op_flush,
  input wire logic i_op_abort,
  input wire logic i_op_user_trap,
  input wire logic i_op_reserved_op_one,
  input wire logic i_op_reserved_op_two,
  input wire logic [LIT_W-1:0] i_trap_literal,
  input wire logic i_ifetch_fault,
  input wire logic i_data_fault,
  input wire logic i_ro_store,
  input wire logic i_cop_trap,
  input wire logic i_timer_irq,
  input wire logic i_ext_irq,
  input wire logic i_parity_err,
  output logic [PSW_W-1:0] o_processor_status_word,
  output logic [BANK_W-1:0] o_bank_select_a,
  output logic [BANK_W-1:0] o_bank_select_b,
  output logic o_ifetch_bypass,
  output logic o_data_bypass,
  output logic o_boot_map,
  output logic [PID_W-1:0] o_pid,
  output logic o_kernel_state_flag,
  output logic o_priv_ok,
  output logic o_parity_check_en,
  output logic o_fetch_load,
  output logic [ADDR_W-1:0] o_fetch_pointer,
  output logic o_restart_go,
  output logic [ADDR_W-1:0] o_restart_addr_first,
  output logic [ADDR_W-1:0] o_restart_addr_second,
  output logic o_mc_reset,
  output logic o_phys_cache_clr_we,
  output logic [$clog2(LINES)-1:0] o_phys_cache_clr_line,
  output logic o_halted
);
  localparam int LINE_W = $clog2(LINES);

  tsc_sub_if #(.LINE_W(LINE_W), .ADDR_W(ADDR_W)) sub ();

  tsc_clear_seq #(.LINES(LINES), .MIN_CYC(CLR_MIN_CYCLES)) u_clr (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .sub(sub.clr)
  );

  tsc_restart_q u_rq (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .sub(sub.rq)
  );

  tsc_state_t state_r;
  logic boot_map_r;
  logic next_krn_r;
  logic krn_r;
  logic priv_r;
  logic chk_inh_r;
  logic [PID_W-1:0] pid_r;
  logic [BANK_W-1:0] bank_a_r;
  logic [BANK_W-1:0] bank_b_r;
  logic imap_byp_r;
  logic dmap_byp_r;
  logic [CAUSE_W-1:0] cause_r;
  logic [LIT_W-1:0] lit_r;

  logic running;
  logic priv_ok;
  logic psw_wr_ok;
  logic [CAUSE_W-1:0] cause_nxt;
  logic trap;
  logic kexit;
  logic halt_evt;
  logic [PSW_W-1:0] psw_view;

  assign running = (state_r == TSC_RUN);
  assign priv_ok = krn_r | priv_r; // [RULE24] [RULE25]
  assign psw_wr_ok = running & i_psw_wr & priv_ok;
  assign kexit = running & i_ex_valid & i_op_kernel_exit & priv_ok;

  // cause terms for this cycle; interrupts enter unmasked, kernel gating comes later at trap
  always_comb
  begin
    cause_nxt = '0;
    cause_nxt[C_EXT] = i_ext_irq; // [RULE4]
    cause_nxt[C_ILL] = i_ex_valid & ((~priv_r & (i_op_special | i_op_set_queue |
      i_op_kernel_exit | i_op_flush)) | i_op_abort | i_op_reserved_op_one |
      i_op_reserved_op_two); // [RULE5]
    cause_nxt[C_ITF] = i_ifetch_fault; // [RULE6]
    cause_nxt[C_DTF] = i_data_fault; // [RULE6]
    cause_nxt[C_WPV] = i_ro_store; // [RULE6]
    cause_nxt[C_COP] = i_cop_trap | i_timer_irq; // [RULE7]
    cause_nxt[C_USR] = i_ex_valid & i_op_user_trap; // [RULE8]
  end

  // only user mode traps; kernel ignores external and coprocessor events
  assign trap = running & ~krn_r & (|cause_nxt); // [RULE24]

  assign halt_evt = running & ((krn_r & (i_ifetch_fault | i_data_fault | i_ro_store)) // [RULE19]
    | (krn_r & i_ex_valid & (i_op_abort | i_op_user_trap | i_op_reserved_op_one
    | i_op_reserved_op_two)) // [RULE20]
    | (~chk_inh_r & i_parity_err)); // [RULE21] [RULE26]

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_r <= TSC_CLEAR;
    else
    begin
      case (state_r)
        TSC_CLEAR:
          if (sub.clr_done)
            state_r <= TSC_RUN;
        TSC_RUN:
          if (halt_evt)
            state_r <= TSC_HALT;
        TSC_HALT:
          state_r <= TSC_HALT; // [RULE22]
        default:
          state_r <= TSC_HALT;
      endcase
    end
  end

  // control fields; pid and bank selects have no reset meaning but get zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      boot_map_r <= 1'b1; // [RULE12]
      next_krn_r <= 1'b1;
      priv_r <= 1'b0;
      chk_inh_r <= 1'b1;
      imap_byp_r <= 1'b1;
      dmap_byp_r <= 1'b1;
      pid_r <= '0;
      bank_a_r <= '0;
      bank_b_r <= '0;
    end
    else if (trap)
    begin
      // trap overrides a simultaneous write, which is dropped for every field
      next_krn_r <= 1'b1; // [RULE17]
      imap_byp_r <= 1'b1;
      dmap_byp_r <= 1'b1;
    end
    else if (psw_wr_ok)
    begin
      boot_map_r <= i_psw_wdata[BOOT_MAP_BIT]; // [RULE10]
      next_krn_r <= i_psw_wdata[NEXT_KRN_BIT];
      priv_r <= i_psw_wdata[PRIV_BIT];
      chk_inh_r <= i_psw_wdata[CHK_INH_BIT];
      pid_r <= i_psw_wdata[PID_LSB +: PID_W];
      bank_a_r <= i_psw_wdata[BANK_A_LSB +: BANK_W];
      bank_b_r <= i_psw_wdata[BANK_B_LSB +: BANK_W];
      imap_byp_r <= i_psw_wdata[IMAP_BYP_BIT];
      dmap_byp_r <= i_psw_wdata[DMAP_BYP_BIT];
    end
  end

  // kernel bit is a one-cycle shadow of next-kernel; trap forces it at once
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      krn_r <= 1'b1; // [RULE12]
    else if (trap)
      krn_r <= 1'b1; // [RULE17]
    else
      krn_r <= next_krn_r; // [RULE23]
  end

  // causes are a fresh snapshot each user cycle, all flags at once
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cause_r <= '0;
      lit_r <= '0;
    end
    else if (running && !krn_r)
    begin
      cause_r <= cause_nxt; // [RULE9] [RULE11]
      if (cause_nxt[C_USR])
        lit_r <= i_trap_literal; // [RULE8]
    end
  end

  always_comb
  begin
    psw_view = '0;
    psw_view[BOOT_MAP_BIT] = boot_map_r;
    psw_view[NEXT_KRN_BIT] = next_krn_r;
    psw_view[KRN_BIT] = krn_r;
    psw_view[PRIV_BIT] = priv_r;
    psw_view[CHK_INH_BIT] = chk_inh_r;
    psw_view[PID_LSB +: PID_W] = pid_r;
    psw_view[BANK_A_LSB +: BANK_W] = bank_a_r;
    psw_view[BANK_B_LSB +: BANK_W] = bank_b_r;
    psw_view[IMAP_BYP_BIT] = imap_byp_r;
    psw_view[DMAP_BYP_BIT] = dmap_byp_r;
    psw_view[CAUSE_LSB +: CAUSE_W] = cause_r;
    psw_view[LIT_LSB +: LIT_W] = lit_r;
  end

  // registered copies; they trail the fields by one cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_processor_status_word <= '0;
      o_bank_select_a <= '0;
      o_bank_select_b <= '0;
      o_ifetch_bypass <= 1'b1;
      o_data_bypass <= 1'b1;
      o_boot_map <= 1'b1;
      o_pid <= '0;
      o_kernel_state_flag <= 1'b1;
      o_priv_ok <= 1'b1;
      o_parity_check_en <= 1'b0;
    end
    else
    begin
      o_processor_status_word <= psw_view;
      o_bank_select_a <= bank_a_r; // [RULE1]
      o_bank_select_b <= bank_b_r; // [RULE2]
      o_ifetch_bypass <= imap_byp_r; // [RULE3]
      o_data_bypass <= dmap_byp_r; // [RULE3]
      o_boot_map <= boot_map_r;
      o_pid <= pid_r;
      o_kernel_state_flag <= krn_r;
      o_priv_ok <= priv_ok;
      o_parity_check_en <= ~chk_inh_r; // [RULE26]
    end
  end

  // fetch redirect: boot address after clear, handler on trap, queue on exit
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fetch_load <= 1'b0;
      o_fetch_pointer <= RESET_FETCH; // [RULE13]
      o_restart_go <= 1'b0;
    end
    else
    begin
      o_fetch_load <= 1'b0;
      o_restart_go <= 1'b0;
      if (state_r == TSC_CLEAR && sub.clr_done)
      begin
        o_fetch_load <= 1'b1;
        o_fetch_pointer <= BOOT_ADDR; // [RULE14]
      end
      else if (halt_evt)
        o_fetch_load <= 1'b0;
      else if (trap)
      begin
        o_fetch_load <= 1'b1;
        o_fetch_pointer <= HANDLER_ADDR; // [RULE16]
      end
      else if (kexit)
      begin
        o_restart_go <= 1'b1; // [RULE18]
        o_fetch_pointer <= sub.rq_second;
      end
    end
  end

  assign sub.rq_shift = running & i_ex_valid & ~trap;
  assign sub.rq_pc = i_ex_pc;
  assign sub.rq_freeze = trap; // [RULE18]
  assign sub.rq_thaw = kexit;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_restart_addr_first <= '0;
      o_restart_addr_second <= '0;
    end
    else
    begin
      o_restart_addr_first <= sub.rq_first;
      o_restart_addr_second <= sub.rq_second;
    end
  end

  // memory controller reset and line writes span the whole clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_mc_reset <= 1'b1; // [RULE15]
      o_phys_cache_clr_we <= 1'b0;
      o_phys_cache_clr_line <= '0;
      o_halted <= 1'b0;
    end
    else
    begin
      o_mc_reset <= sub.clr_busy; // [RULE15]
      o_phys_cache_clr_we <= sub.clr_busy; // [RULE13]
      o_phys_cache_clr_line <= sub.clr_line;
      o_halted <= (state_r == TSC_HALT) | halt_evt; // [RULE22]
    end
  end
endmodule
`default_nettype wire

// [test/tsc_props.sv]
/*
  tsc_props: port-level timing checks for tsc_top.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tsc_props
  import tsc_pkg::*;
#(
  parameter int LINES = CACHE_LINES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psw_wr,
  input wire logic i_ext_irq,
  input wire logic i_parity_err,
  input wire logic [PSW_W-1:0] o_processor_status_word,
  input wire logic o_ifetch_bypass,
  input wire logic o_data_bypass,
  input wire logic o_kernel_state_flag,
  input wire logic o_parity_check_en,
  input wire logic o_fetch_load,
  input wire logic [ADDR_W-1:0] o_fetch_pointer,
  input wire logic o_mc_reset,
  input wire logic o_phys_cache_clr_we,
  input wire logic [$clog2(LINES)-1:0] o_phys_cache_clr_line,
  input wire logic o_halted
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [11:0] clr_cnt_r;
  // saturates so a stuck reset output cannot wrap the count
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      clr_cnt_r <= 12'h000;
    else if (o_mc_reset && clr_cnt_r != 12'hFFF)
      clr_cnt_r <= clr_cnt_r + 12'h001;
  a_halt_stays: assert property (o_halted |=> o_halted)
    else $error("halt released without reset");
  a_clear_long: assert property ($fell(o_mc_reset) |-> clr_cnt_r >= 12'h400)
    else $error("cache clear too short");
  a_boot_fetch: assert property ($fell(o_mc_reset) |-> ##[0:3]
    (o_fetch_load && o_fetch_pointer == BOOT_ADDR))
    else $error("no boot fetch after clear");
  a_line_walk: assert property (o_phys_cache_clr_we && $past(o_phys_cache_clr_we)
    |-> o_phys_cache_clr_line == $past(o_phys_cache_clr_line) + 1'b1)
    else $error("clear line index skipped");
  a_clr_in_reset: assert property (o_phys_cache_clr_we |-> o_mc_reset)
    else $error("line clear outside reset");
  a_trap_vector: assert property (i_ext_irq && !o_kernel_state_flag && !o_fetch_load && !o_halted
    && !o_mc_reset && !i_parity_err && !$past(i_psw_wr) && !$past(i_psw_wr, 2)
    |=> o_fetch_load && o_fetch_pointer == HANDLER_ADDR)
    else $error("interrupt did not vector");
  a_trap_mode: assert property (o_fetch_load && o_fetch_pointer == HANDLER_ADDR
    |=> o_kernel_state_flag && o_ifetch_bypass && o_data_bypass)
    else $error("trap entry mode bits wrong");
  // the view reads zero in reset and trap entry forces kernel at once, so both edges are exempt
  a_kernel_follow: assert property ($past(i_rst_n, 2) && !($past(o_fetch_load)
    && $past(o_fetch_pointer) == HANDLER_ADDR)
    |-> o_processor_status_word[KRN_BIT] == $past(o_processor_status_word[NEXT_KRN_BIT]))
    else $error("kernel bit not following next-kernel");
  a_cause_hold: assert property ($past(o_processor_status_word[KRN_BIT]) |-> $stable(o_processor_status_word[12:0]))
    else $error("cause fields moved in kernel");
  a_parity_halt: assert property (i_parity_err && o_parity_check_en && !o_mc_reset && !o_fetch_load
    && !$past(i_psw_wr) && !$past(i_psw_wr, 2) |=> o_halted)
    else $error("parity error did not halt");
  c_trap: cover property (o_fetch_load && o_fetch_pointer == HANDLER_ADDR);
  c_halt: cover property ($rose(o_halted));
  c_clear_done: cover property ($fell(o_mc_reset));
endmodule
`default_nettype wire

// [test/tsc_mc_model.sv]
/*
  tsc_mc_model: memory controller stand-in that raises the external
  interrupt a fixed delay after a request. Assumes the processor clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tsc_mc_model #(
  parameter int DLY = 2
)
(
  input wire logic i_ref_clk,
  input wire logic i_mc_reset,
  input wire logic i_raise,
  output logic o_irq
);
  logic [DLY-1:0] pipe_r;
  // a controller held in reset keeps its request line quiet
  always_ff @(posedge i_ref_clk)
    if (i_mc_reset)
      pipe_r <= '0;
    else
      pipe_r <= {pipe_r[DLY-2:0], i_raise};
  assign o_irq = pipe_r[DLY-1] & ~i_mc_reset;
endmodule
`default_nettype wire

// [test/tb_top.sv]
/*
  tb_top: directed scenarios for tsc_top beside a memory controller model.
  Assumes 200 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic xv = 1'b0;
  logic [31:0] pc = '0;
  logic [7:0] op = '0;
  logic [5:0] lit = '0;
  logic [6:0] f = '0;
  logic raise = 1'b0;
  logic irq, fl, go, mcr, hlt, kf, iby, dby, pok, bm;
  logic [7:0] pd;
  logic [1:0] ba, bb;
  logic [31:0] processor_status_word, fp, qf, qs;
  int err_count = 0;
  int comparisons = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  tsc_mc_model u_tsc_mc_model (.i_ref_clk(i_ref_clk), .i_mc_reset(mcr), .i_raise(raise), .o_irq(irq));
  tsc_top #(.LINES(16)) u_tsc_top (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psw_wr(wr),
    .i_psw_wdata(wd), .i_ex_valid(xv), .i_ex_pc(pc), .i_op_special(op[0]), .i_op_set_queue(op[1]),
    .i_op_kernel_exit(op[2]), .i_op_flush(op[3]), .i_op_abort(op[4]), .i_op_user_trap(op[5]),
    .i_op_reserved_op_one(op[6]), .i_op_reserved_op_two(op[7]), .i_trap_literal(lit),
    .i_ifetch_fault(f[0]), .i_data_fault(f[1]), .i_ro_store(f[2]), .i_cop_trap(f[3]),
    .i_timer_irq(f[4]), .i_ext_irq(irq), .i_parity_err(f[5]), .o_processor_status_word(processor_status_word),
    .o_bank_select_a(ba), .o_bank_select_b(bb), .o_ifetch_bypass(iby), .o_data_bypass(dby),
    .o_boot_map(bm), .o_pid(pd), .o_kernel_state_flag(kf), .o_priv_ok(pok), .o_parity_check_en(),
    .o_fetch_load(fl), .o_fetch_pointer(fp), .o_restart_go(go), .o_restart_addr_first(qf),
    .o_restart_addr_second(qs), .o_mc_reset(mcr), .o_phys_cache_clr_we(), .o_phys_cache_clr_line(),
    .o_halted(hlt));
  task automatic test_done;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stp(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // bounded wait for a fetch load, counting reset-output cycles meanwhile
  task automatic wait_load(input int lim, output int hi);
    int i;
    hi = 0;
    for (i = 0; i < lim && fl !== 1'b1; i++)
    begin
      stp(1);
      hi += int'(mcr === 1'b1);
    end
    if (fl !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t fetch load timeout", $time);
      test_done();
    end
  endtask
  task automatic wrp(input logic [31:0] d);
    wr = 1'b1;
    wd = d;
    stp(1);
    wr = 1'b0;
    stp(3);
  endtask
  task automatic exe(input logic [31:0] a, input logic [7:0] o, input logic [6:0] ff, input bit hold = 1'b0);
    xv = 1'b1;
    pc = a;
    op = o;
    f = ff;
    stp(1);
    // a held op is overwritten by the next call, never lowered and raised in one step
    if (!hold)
    begin
      xv = 1'b0;
      op = '0;
      f = '0;
    end
  endtask
  task automatic t_boot;
    int n;
    i_rst_n = 1'b0;
    stp(8);
    chk(processor_status_word, 0);
    chk(fp, 0);
    chk(mcr, 1);
    i_rst_n = 1'b1;
    wait_load(1200, n);
    chk(fp, BOOT_ADDR);
    chk(n >= CLR_MIN_CYCLES, 1);
    stp(3);
    chk(processor_status_word, 32'hE800_6000);
    $display("boot done");
  endtask
  task automatic t_write;
    wrp(32'h4D2C_9FFF);
    chk(processor_status_word, 32'h6D2C_8000);
    chk(ba, 2);
    chk(bb, 1);
    chk({iby, dby}, 0);
    chk(bm, 0);
    chk(pd, 8'hA5);
    $display("write done");
  endtask
  task automatic t_user;
    wrp(32'h0D2C_9FFF);
    chk({kf, pok}, 0);
    wrp(32'h1000_0000);
    chk(processor_status_word, 32'h0D2C_8000);
    $display("user done");
  endtask
  task automatic t_trap;
    int n;
    raise = 1'b1;
    exe(32'h0000_0100, 8'h00, 7'h00, 1'b1);
    raise = 1'b0;
    exe(32'h0000_0104, 8'h00, 7'h00, 1'b1);
    lit = 6'h2A;
    exe(32'h0000_0108, 8'h20, 7'h01);
    wait_load(4, n);
    chk(fp, HANDLER_ADDR);
    stp(3);
    chk(processor_status_word, 32'h6D2C_F46A);
    chk(qf, 32'h0000_0104);
    chk(qs, 32'h0000_0100);
    $display("trap done");
  endtask
  task automatic t_exit;
    exe(32'h0000_0200, 8'h00, 7'h00, 1'b1);
    chk(qf, 32'h0000_0104);
    exe(32'h0000_0204, 8'h04, 7'h00);
    chk({go, fp}, {1'b1, 32'h0000_0100});
    $display("exit done");
  endtask
  task automatic t_trap2;
    int n;
    wrp(32'h1D2C_8000);
    // privilege enable lets a user-mode special op pass without a trap
    exe(32'h0000_02FC, 8'h01, 7'h00, 1'b1);
    chk(fl, 0);
    exe(32'h0000_0300, 8'h10, 7'h16);
    wait_load(4, n);
    stp(3);
    chk(processor_status_word[12:6], 7'b0101110);
    raise = 1'b1;
    f = 7'h08;
    repeat (6)
    begin
      stp(1);
      chk(fl, 0);
    end
    raise = 1'b0;
    f = '0;
    stp(3);
    $display("trap2 done");
  endtask
  task automatic t_halt;
    exe(32'h0000_0400, 8'h10, 7'h00);
    stp(1);
    chk(hlt, 1);
    exe(32'h0000_0404, 8'h04, 7'h00);
    stp(20);
    chk({hlt, fl, go}, 3'b100);
    $display("halt done");
  endtask
  task automatic t_parity;
    t_boot();
    f = 7'h20;
    stp(3);
    f = '0;
    chk(hlt, 0);
    wrp(32'h4000_0000);
    exe(32'h0000_0500, 8'h00, 7'h20);
    stp(1);
    chk(hlt, 1);
    $display("parity done");
  endtask
  task automatic t_kfault;
    t_boot();
    exe(32'h0000_0600, 8'h00, 7'h02);
    stp(1);
    chk(hlt, 1);
    $display("kernel fault done");
  endtask
  initial
  begin
    t_boot();
    t_write();
    t_user();
    t_trap();
    t_exit();
    t_trap2();
    t_halt();
    t_parity();
    t_kfault();
    test_done();
  end
endmodule
bind tsc_top tsc_props #(.LINES(LINES)) u_tsc_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_psw_wr(i_psw_wr), .i_ext_irq(i_ext_irq), .i_parity_err(i_parity_err),
  .o_processor_status_word(o_processor_status_word), .o_ifetch_bypass(o_ifetch_bypass),
  .o_data_bypass(o_data_bypass), .o_kernel_state_flag(o_kernel_state_flag),
  .o_parity_check_en(o_parity_check_en), .o_fetch_load(o_fetch_load), .o_fetch_pointer(o_fetch_pointer),
  .o_mc_reset(o_mc_reset), .o_phys_cache_clr_we(o_phys_cache_clr_we),
  .o_phys_cache_clr_line(o_phys_cache_clr_line), .o_halted(o_halted));
`default_nettype wire
